// File: logic/sbc_supply_bist_control.sv
// Supply self-test control: AXI4-Lite registers, fault status, fault output and interrupt
// Behaviour
// - A one written to the go bit starts a self-test run and the bit then clears itself and reads ready.
// - Each run exercises the regulator comparators one after another, checking that each detects a fault.
// - With keep-faults at zero, both fault status registers clear and the fault output releases at run end.
// - With keep-faults at one, both fault status registers and the asserted fault output are kept at run end.
// - With keep-faults set, a run started by the go bit never clears the first or second fault register.
`timescale 1ns/1ps
`default_nettype none
module sbc_supply_bist_control (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  input  wire logic [sbc_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [sbc_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [sbc_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [sbc_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [sbc_pkg::NUM_COMP-1:0]   comp_trip_in,
  output logic [sbc_pkg::NUM_COMP-1:0]        comp_test_force,
  output logic                                fault_output_low_active,
  output logic                                irq
);
  import sbc_pkg::*;

  sbc_seq_if sq ();

  sbc_sequencer u_seq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .sq      (sq)
  );

  logic                    aw_held_q;
  logic [ADDR_W-1:0]       awaddr_q;
  logic                    w_held_q;
  logic [DATA_W-1:0]       wdata_q;
  logic [3:0]              wstrb_q;
  logic                    wr_fire;
  logic                    wr_lane0;
  sbc_reg_t                wr_sel;
  logic                    go_q;
  logic                    keep_q;
  logic                    keep_run_q;
  logic                    start_q;
  logic [NUM_COMP-1:0]     fault1_q;
  logic [NUM_COMP-1:0]     fault2_q;
  logic [IRQ_W-1:0]        irq_stat_q;
  logic [IRQ_W-1:0]        irq_mask_q;
  logic [NUM_COMP-1:0]     sync1_q;
  logic [NUM_COMP-1:0]     sync2_q;
  logic [NUM_COMP-1:0]     sync3_q;
  logic [NUM_COMP-1:0]     tripped_q;
  logic [NUM_COMP-1:0]     tripped_prev_q;
  logic                    end_clr;
  logic [IRQ_W-1:0]        irq_evt;

  // Address decode shared by the write and read paths
  function automatic sbc_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
    sbc_reg_t sel;
    sel = SBC_REG_NONE;
    if (addr == {IDX_CTRL[ADDR_W-3:0], 2'b00}) begin
      sel = SBC_REG_CTRL;
    end else if (addr == {IDX_FAULT1[ADDR_W-3:0], 2'b00}) begin
      sel = SBC_REG_FAULT1;
    end else if (addr == {IDX_FAULT2[ADDR_W-3:0], 2'b00}) begin
      sel = SBC_REG_FAULT2;
    end else if (addr == {IDX_IRQ_STAT[ADDR_W-3:0], 2'b00}) begin
      sel = SBC_REG_IRQ_STAT;
    end else if (addr == {IDX_IRQ_MASK[ADDR_W-3:0], 2'b00}) begin
      sel = SBC_REG_IRQ_MASK;
    end
    return sel;
  endfunction

  // A write lands once both halves are held and the last response is gone
  assign wr_fire  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_sel   = reg_decode(awaddr_q);
  assign wr_lane0 = wr_fire && wstrb_q[0];

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      awaddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end else if (!aw_held_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end else if (!w_held_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == SBC_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data one cycle after the address is taken, no read side effects
  // Ready returns one idle cycle after each answer, so reads never overlap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= '0;
        case (reg_decode(s_axi_araddr))
          SBC_REG_CTRL: begin
            s_axi_rdata[CTRL_GO_BIT]   <= go_q;
            s_axi_rdata[CTRL_KEEP_BIT] <= keep_q;
          end
          SBC_REG_FAULT1:   s_axi_rdata[NUM_COMP-1:0] <= fault1_q;
          SBC_REG_FAULT2:   s_axi_rdata[NUM_COMP-1:0] <= fault2_q;
          SBC_REG_IRQ_STAT: s_axi_rdata[IRQ_W-1:0]    <= irq_stat_q;
          SBC_REG_IRQ_MASK: s_axi_rdata[IRQ_W-1:0]    <= irq_mask_q;
          default:          s_axi_rresp               <= RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Control register; a go written during a run waits and starts the next one
  // Keep-faults is latched at launch so a later change cannot alter a run in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_q       <= CTRL_RESET[CTRL_GO_BIT];
      keep_q     <= CTRL_RESET[CTRL_KEEP_BIT];
      keep_run_q <= CTRL_RESET[CTRL_KEEP_BIT];
      start_q    <= 1'b0;
    end else if (ce) begin
      start_q <= 1'b0;
      if (go_q && !sq.busy && !start_q) begin
        start_q    <= 1'b1;
        go_q       <= 1'b0;
        keep_run_q <= keep_q;
      end
      if (wr_lane0 && wr_sel == SBC_REG_CTRL) begin
        keep_q <= wdata_q[CTRL_KEEP_BIT];
        if (wdata_q[CTRL_GO_BIT]) begin
          go_q <= 1'b1;
        end
      end
    end
  end

  // Sequencer sees trip levels only after the agreement filter
  assign sq.start   = start_q;
  assign sq.tripped = tripped_q;

  // Comparator outputs are asynchronous; three stages, accepted when the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (ce) begin
      sync1_q <= comp_trip_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Per-bit filter: a level counts only when two stages agree, so a glitch is ignored
  generate
    for (genvar i = 0; i < NUM_COMP; i++) begin : g_trip
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tripped_q[i] <= 1'b0;
        end else if (ce && (sync2_q[i] == sync3_q[i])) begin
          tripped_q[i] <= sync3_q[i];
        end
      end
    end
  endgenerate

  // Run-end clear only when the run was started with keep-faults clear
  assign end_clr = sq.done && !keep_run_q;

  // Fault status: new trips and failures win over any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault1_q <= FAULT_RESET;
      fault2_q <= FAULT_RESET;
    end else if (ce) begin
      if (end_clr) begin
        fault1_q <= tripped_q;
        fault2_q <= sq.fail;
      end else begin
        fault1_q <= (fault1_q & ~((wr_lane0 && wr_sel == SBC_REG_FAULT1) ? wdata_q[NUM_COMP-1:0] : '0))
                    | tripped_q;
        fault2_q <= (fault2_q & ~((wr_lane0 && wr_sel == SBC_REG_FAULT2) ? wdata_q[NUM_COMP-1:0] : '0))
                    | sq.fail;
      end
    end
  end

  // Fault output stays low while any status bit is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_output_low_active <= 1'b1;
    end else if (ce) begin
      fault_output_low_active <= !(|fault1_q || |fault2_q);
    end
  end

  // Comparator forcing is registered here at the port as well as inside the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tripped_prev_q  <= '0;
      comp_test_force <= '0;
    end else if (ce) begin
      tripped_prev_q  <= tripped_q;
      comp_test_force <= sq.force_trip;
    end
  end

  // Live trips count only while idle; during a run they are expected
  always_comb begin
    irq_evt               = '0;
    irq_evt[IRQ_DONE_BIT] = sq.done;
    irq_evt[IRQ_FAIL_BIT] = sq.done && sq.fail_any;
    irq_evt[IRQ_LIVE_BIT] = !sq.busy && |(tripped_q & ~tripped_prev_q);
  end

  // Interrupt status is write-one-to-clear; an event in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= IRQ_STAT_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~((wr_lane0 && wr_sel == SBC_REG_IRQ_STAT) ? wdata_q[IRQ_W-1:0] : '0))
                    | irq_evt;
      if (wr_lane0 && wr_sel == SBC_REG_IRQ_MASK) begin
        irq_mask_q <= wdata_q[IRQ_W-1:0];
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule
`default_nettype wire

// File: logic/sbc_pkg.sv
// Constants and types shared by the supply self-test control block
package sbc_pkg;

  // Number of regulator comparators walked by one self-test run
  localparam int NUM_COMP = 4;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CTRL     = 12'h337;
  localparam logic [ADDR_W-1:0] IDX_FAULT1   = 12'h340;
  localparam logic [ADDR_W-1:0] IDX_FAULT2   = 12'h341;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h342;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h343;

  // Control register fields
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_KEEP_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Fault status reset value
  localparam logic [NUM_COMP-1:0] FAULT_RESET = 4'h0;

  // Interrupt status and mask fields
  localparam int IRQ_W        = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_LIVE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Timing: each comparator is forced, then released, for one step each
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_TIME_NS  = 5000;
  localparam int STEP_CYC_INT  = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'(STEP_CYC_INT);

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SBC_SEQ_IDLE    = 2'b00,
    SBC_SEQ_FORCE   = 2'b01,
    SBC_SEQ_RECOVER = 2'b10,
    SBC_SEQ_DONE    = 2'b11
  } sbc_seq_state_t;

  typedef enum logic [2:0] {
    SBC_REG_NONE     = 3'b000,
    SBC_REG_CTRL     = 3'b001,
    SBC_REG_FAULT1   = 3'b010,
    SBC_REG_FAULT2   = 3'b011,
    SBC_REG_IRQ_STAT = 3'b100,
    SBC_REG_IRQ_MASK = 3'b101
  } sbc_reg_t;

endpackage

// File: logic/sbc_seq_if.sv
// Carrier between the register front end and the comparator sequencer
`timescale 1ns/1ps
`default_nettype none
interface sbc_seq_if;
  import sbc_pkg::*;
  logic                start;
  logic                busy;
  logic                done;
  logic                fail_any;
  logic [NUM_COMP-1:0] fail;
  logic [NUM_COMP-1:0] force_trip;
  logic [NUM_COMP-1:0] tripped;

  modport ctrl (output start, output tripped,
                input busy, input done, input fail_any, input fail, input force_trip);
  modport seq  (input start, input tripped,
                output busy, output done, output fail_any, output fail, output force_trip);
endinterface
`default_nettype wire

// File: logic/sbc_sequencer.sv
// Steps the self-test through each regulator comparator in turn
`timescale 1ns/1ps
`default_nettype none
module sbc_sequencer (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  sbc_seq_if.seq    sq
);
  import sbc_pkg::*;

  sbc_seq_state_t                  state_q;
  logic [$clog2(NUM_COMP)-1:0]     idx_q;
  logic [CNT_W-1:0]                cnt_q;
  logic [NUM_COMP-1:0]             fail_q;
  logic [NUM_COMP-1:0]             force_q;
  logic                            done_q;
  logic                            fail_any_q;

  assign sq.busy       = (state_q != SBC_SEQ_IDLE);
  assign sq.done       = done_q;
  assign sq.fail_any   = fail_any_q;
  assign sq.fail       = fail_q;
  assign sq.force_trip = force_q;

  // One comparator at a time, so a failure points at a single regulator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SBC_SEQ_IDLE;
      idx_q   <= '0;
      cnt_q   <= '0;
      fail_q  <= '0;
      force_q <= '0;
    end else if (ce) begin
      case (state_q)
        SBC_SEQ_IDLE: begin
          if (sq.start) begin
            idx_q   <= '0;
            fail_q  <= '0;
            force_q <= NUM_COMP'(1);
            cnt_q   <= STEP_CYC - 8'h01;
            state_q <= SBC_SEQ_FORCE;
          end
        end
        SBC_SEQ_FORCE: begin
          if (cnt_q == '0) begin
            if (!sq.tripped[idx_q]) begin
              fail_q[idx_q] <= 1'b1;
            end
            force_q <= '0;
            cnt_q   <= STEP_CYC - 8'h01;
            state_q <= SBC_SEQ_RECOVER;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        SBC_SEQ_RECOVER: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (idx_q == ($clog2(NUM_COMP))'(NUM_COMP - 1)) begin
            fail_q  <= '0;
            state_q <= SBC_SEQ_DONE;
          end else begin
            idx_q   <= idx_q + 1'b1;
            force_q <= NUM_COMP'(1) << (idx_q + 1'b1);
            cnt_q   <= STEP_CYC - 8'h01;
            state_q <= SBC_SEQ_FORCE;
          end
        end
        SBC_SEQ_DONE: begin
          state_q <= SBC_SEQ_IDLE;
        end
        default: begin
          state_q <= SBC_SEQ_IDLE;
        end
      endcase
    end
  end

  // End-of-run pulse with the summary of the run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q     <= 1'b0;
      fail_any_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (state_q == SBC_SEQ_RECOVER && cnt_q == '0 &&
          idx_q == ($clog2(NUM_COMP))'(NUM_COMP - 1)) begin
        done_q     <= 1'b1;
        fail_any_q <= |fail_q;
      end
    end
  end

endmodule
`default_nettype wire

// File: dv/sbc_asserts.sv
// Concurrent checks on the ports of the supply self-test control block
`timescale 1ns/1ps
`default_nettype none
module sbc_asserts
  import sbc_pkg::*;
(
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                ce,
  input wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [DATA_W-1:0]   s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [DATA_W-1:0]   s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [NUM_COMP-1:0] comp_test_force
);
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {IDX_CTRL[ADDR_W-3:0], 2'b00};
  logic [NUM_COMP-1:0] prev_q;
  logic [NUM_COMP-1:0] last_q;
  int                  cnt_q;
  // Run length of each force value, and the last comparator forced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
      last_q <= '0;
      cnt_q  <= 0;
    end else if (ce) begin
      prev_q <= comp_test_force;
      cnt_q  <= (comp_test_force == prev_q) ? cnt_q + 1 : 1;
      if (comp_test_force != '0) begin
        last_q <= comp_test_force;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_go_wr;
    s_wr_take ##0 (s_axi_awaddr == CTRL_ADDR && s_axi_wstrb[0] && s_axi_wdata[CTRL_GO_BIT]);
  endsequence
  property p_force_onehot;
    $onehot0(comp_test_force);
  endproperty
  a_force_onehot: assert property (p_force_onehot) else $error("force not one-hot");
  property p_force_len;
    (prev_q != '0 && comp_test_force != prev_q) |-> cnt_q == int'(STEP_CYC);
  endproperty
  a_force_len: assert property (p_force_len) else $error("force step length wrong");
  property p_force_order;
    (comp_test_force != '0 && prev_q == '0) |->
      comp_test_force == ((last_q == '0 || last_q[NUM_COMP-1]) ? 1 : last_q << 1);
  endproperty
  a_force_order: assert property (p_force_order) else $error("comparator order wrong");
  property p_go_start;
    s_go_wr |-> ##[1:1000] (comp_test_force != '0);
  endproperty
  a_go_start: assert property (p_go_start) else $error("go did not start a run");
  property p_b_answer;
    s_wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_busy_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while busy");
endmodule
bind sbc_supply_bist_control sbc_asserts i_sbc_asserts (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .comp_test_force);
`default_nettype wire

// File: dv/sbc_supply_bist_control_tb.sv
// Self-checking bench for the supply self-test control block
`timescale 1ns/1ps
`default_nettype none
module sbc_supply_bist_control_tb;
  import sbc_pkg::*;
  logic                aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready, fout, irq;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic [DATA_W-1:0]   wdata, rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp;
  logic [NUM_COMP-1:0] trip, force_v, brk, last_f;
  logic [NUM_COMP-1:0] fseq[$];
  logic [ADDR_W-1:0]   idx_list [5];
  int                  n_errors, num_checks;
  sbc_supply_bist_control i_sbc_supply_bist_control (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .comp_trip_in(trip), .comp_test_force(force_v),
    .fault_output_low_active(fout), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Comparators trip when forced unless marked broken; the force order is logged
  always @(posedge aclk) begin
    trip <= force_v & ~brk;
    last_f <= force_v;
    if (force_v !== '0 && force_v !== last_f) fseq.push_back(force_v);
  end
  function automatic logic [ADDR_W-1:0] ba(input logic [ADDR_W-1:0] i);
    return i << 2;
  endfunction
  function automatic logic [31:0] kept(input logic k, input logic [3:0] v);
    return k ? {28'h0, v} : 32'h0;
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    n_errors++;
    results();
  endtask
  // Master holds each channel until its own ready; bready and rready start random and go high once the response is valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom);
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    if (i == 100) hang();
    r = bresp;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom);
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (i == 100) hang();
    d = rdata;
    r = rresp;
  endtask
  // One run: k keep option, b broken comparators, m done-irq mask, c flip keep mid-run
  task automatic run(input logic k, input logic [3:0] b, input logic m, input logic c);
    logic [31:0] d;
    logic [1:0]  r;
    int          j;
    brk <= b;
    fseq = {};
    wr(ba(IDX_IRQ_MASK), {31'h0, m}, r);
    wr(ba(IDX_CTRL), {30'h0, k, 1'b1}, r);
    chk({30'h0, r}, RESP_OKAY);
    if (c) wr(ba(IDX_CTRL), {30'h0, ~k, 1'b0}, r);
    for (j = 0; j < 300; j++) begin
      rd(ba(IDX_IRQ_STAT), d, r);
      if (d[IRQ_DONE_BIT]) break;
    end
    if (j == 300) hang();
    repeat (4) @(posedge aclk);
    chk(fseq.size(), NUM_COMP);
    for (j = 0; j < NUM_COMP; j++) chk({28'h0, fseq[j]}, 32'h1 << j);
    chk({31'h0, irq}, {31'h0, m});
    chk(d, {29'h0, b != 4'h0, 1'b1});
    rd(ba(IDX_CTRL), d, r);
    chk(d, {30'h0, k ^ c, 1'b0});
    rd(ba(IDX_FAULT1), d, r);
    chk(d, kept(k, ~b));
    rd(ba(IDX_FAULT2), d, r);
    chk(d, kept(k, b));
    chk({31'h0, fout}, {31'h0, ~k});
    wr(ba(IDX_FAULT1), 32'hf, r);
    wr(ba(IDX_FAULT2), 32'hf, r);
    wr(ba(IDX_IRQ_STAT), 32'h7, r);
    repeat (3) @(posedge aclk);
    chk({30'h0, fout, irq}, 32'h2);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [6:0]  rv;
    int          n;
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, brk} = '0;
    {ce, bready, rready} = 3'b111;
    wstrb = 4'hf;
    n_errors = 0;
    num_checks = 0;
    rv = 7'($urandom(32'h4d085e5e));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, fout, irq}, 32'h2);
    idx_list = '{IDX_CTRL, IDX_FAULT1, IDX_FAULT2, IDX_IRQ_STAT, IDX_IRQ_MASK};
    foreach (idx_list[i]) begin
      rd(ba(idx_list[i]), d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, RESP_OKAY);
    end
    wr(12'hd10, 32'h3, r);
    chk({30'h0, r}, RESP_SLVERR);
    rd(12'hd10, d, r);
    chk({d[29:0], r}, RESP_SLVERR);
    // Clock enable low must freeze the bus: a pending read gets no answer
    ce <= 1'b0;
    araddr <= ba(IDX_CTRL);
    arvalid <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, rvalid}, 32'h0);
    ce <= 1'b1;
    rd(ba(IDX_CTRL), d, r);
    chk(d, 32'h0);
    run(1'b0, 4'($urandom), 1'b0, 1'b0);
    run(1'b1, 4'($urandom_range(1, 15)), 1'b1, 1'b1);
    run(1'b1, 4'h0, 1'b0, 1'b1);
    run(1'b0, 4'hf, 1'b1, 1'b1);
    for (n = 0; n < 3; n++) begin
      rv = 7'($urandom);
      run(rv[0], rv[4:1], rv[5], rv[6]);
    end
    results();
  end
endmodule
`default_nettype wire
